// file: hw/line_tx_channel_control.sv
// Functional notes
// RULE_01 - Bit 5 picks the drive-monitor source: 0 uses the monitor input pins, 1 watches the output pads.
// RULE_02 - The drive-monitor alarm rises after 128 bit periods with no bipolar pulse and falls on the next pulse.
// RULE_03 - A 0-to-1 write of bit 4 inserts exactly one bit error into the outgoing test pattern.
// RULE_04 - Error insertion acts only while both the pattern generator and its receiver are enabled.
// RULE_05 - Software must write bit 4 back to 0 before another rising write can insert an error.
// RULE_06 - Bit 2 set replaces the system data by an unframed all-ones line pattern.
// RULE_07 - Bit 1 selects the transmit clock edge that samples the dual-rail data: 0 falling, 1 rising.
// RULE_08 - Software sets bit 0 to 0 for cable of 225 feet or less and to 1 for longer cable.
// RULE_09 - The build-out select has no effect in E3 operation.
// RULE_10 - Each of the twelve channels has its own transmit control register at sub-address 4.
// RULE_11 - Reserved bits 3, 6 and 7 read as 0 and ignore writes.
module line_tx_channel_control (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Microprocessor port
  input wire logic [3:0] cpu_channel,
  input wire logic [3:0] cpu_sub_address,
  input wire logic cpu_write,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  // Per-channel mode
  input wire logic [11:0] mode_e3,
  input wire logic [11:0] prbs_gen_enable,
  input wire logic [11:0] prbs_rx_enable,
  input wire logic [11:0] prbs_data,
  // System side
  input wire logic [11:0] system_tx_clock,
  input wire logic [11:0] system_tx_data_pos,
  input wire logic [11:0] system_tx_data_neg,
  // Line side
  input wire logic [11:0] monitor_in_positive,
  input wire logic [11:0] monitor_in_negative,
  output logic [11:0] line_out_positive,
  output logic [11:0] line_out_negative,
  output logic [11:0] line_buildout_enable,
  output logic [11:0] prbs_error_insert,
  output logic [11:0] drive_monitor_alarm
);
  logic [7:0] tx_control_ff [12];
  logic [7:0] nxt_tx_control [12];
  logic [11:0] clk_meta_ff, clk_sync_ff, clk_prev_ff;
  logic [11:0] pos_meta_ff, pos_sync_ff, neg_meta_ff, neg_sync_ff;
  logic [11:0] mp_meta_ff, mp_sync_ff, mn_meta_ff, mn_sync_ff;
  logic [11:0] out_pos_ff, out_neg_ff, nxt_out_pos, nxt_out_neg;
  logic [11:0] err_ff, nxt_err;
  logic [11:0] alarm_ff, nxt_alarm;
  logic [7:0] silent_ff [12];
  logic [7:0] nxt_silent [12];

  logic [11:0] edge_hit;
  logic [11:0] pulse_seen;

  function automatic logic [7:0] clean(input logic [7:0] value);
    clean = value & line_tx_pkg::tx_control_mask;
  endfunction : clean

  function automatic logic page_hit(input logic [3:0] channel, input logic [3:0] sub_address, input int ch);
    page_hit = channel == 4'(ch) && sub_address == line_tx_pkg::sub_tx_control;
  endfunction : page_hit

  // Two-flop synchronisers for every pin from outside the clk_sys domain
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      clk_meta_ff <= '0;
      clk_sync_ff <= '0;
      clk_prev_ff <= '0;
      pos_meta_ff <= '0;
      pos_sync_ff <= '0;
      neg_meta_ff <= '0;
      neg_sync_ff <= '0;
      mp_meta_ff <= '0;
      mp_sync_ff <= '0;
      mn_meta_ff <= '0;
      mn_sync_ff <= '0;
    end else begin
      clk_meta_ff <= system_tx_clock;
      clk_sync_ff <= clk_meta_ff;
      clk_prev_ff <= clk_sync_ff;
      pos_meta_ff <= system_tx_data_pos;
      pos_sync_ff <= pos_meta_ff;
      neg_meta_ff <= system_tx_data_neg;
      neg_sync_ff <= neg_meta_ff;
      mp_meta_ff <= monitor_in_positive;
      mp_sync_ff <= mp_meta_ff;
      mn_meta_ff <= monitor_in_negative;
      mn_sync_ff <= mn_meta_ff;
    end
  end

  // Selected transmit clock edge, seen in the same cycle the synchronised clock shows it
  always_comb begin
    for (int ch = 0; ch < line_tx_pkg::num_channels; ch++) begin
      if (tx_control_ff[ch][line_tx_pkg::bit_clock_edge]) begin
        edge_hit[ch] = clk_sync_ff[ch] && !clk_prev_ff[ch]; // RULE_07
      end else begin
        edge_hit[ch] = !clk_sync_ff[ch] && clk_prev_ff[ch]; // RULE_07
      end
    end
  end

  // Register page: one copy per channel, reserved bits never stored
  always_comb begin
    for (int ch = 0; ch < line_tx_pkg::num_channels; ch++) begin
      nxt_tx_control[ch] = tx_control_ff[ch];
      if (cpu_write && page_hit(cpu_channel, cpu_sub_address, ch)) begin // RULE_10
        nxt_tx_control[ch] = clean(cpu_wdata); // RULE_11
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    for (int ch = 0; ch < line_tx_pkg::num_channels; ch++) begin
      if (!nrst) begin
        tx_control_ff[ch] <= line_tx_pkg::tx_control_reset;
      end else begin
        tx_control_ff[ch] <= nxt_tx_control[ch];
      end
    end
  end

  // Error request: a new request wins over a consuming edge in the same cycle
  always_comb begin
    for (int ch = 0; ch < line_tx_pkg::num_channels; ch++) begin
      nxt_err[ch] = err_ff[ch];
      // Spent on the next transmitted bit; dropped if the generator stops, so it never lingers
      if (edge_hit[ch] || !prbs_gen_enable[ch]) begin
        nxt_err[ch] = 1'b0;
      end
      // Only a fresh rising write counts; holding the bit at 1 does nothing more
      if (cpu_write && page_hit(cpu_channel, cpu_sub_address, ch)
          && cpu_wdata[line_tx_pkg::bit_insert_error]
          && !tx_control_ff[ch][line_tx_pkg::bit_insert_error]) begin // RULE_03 RULE_05
        if (prbs_gen_enable[ch] && prbs_rx_enable[ch]) begin // RULE_04
          nxt_err[ch] = 1'b1; // RULE_03
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      err_ff <= '0;
    end else begin
      err_ff <= nxt_err;
    end
  end

  // Line rails: loaded only on the selected edge, otherwise held
  always_comb begin
    for (int ch = 0; ch < line_tx_pkg::num_channels; ch++) begin
      nxt_out_pos[ch] = out_pos_ff[ch];
      nxt_out_neg[ch] = out_neg_ff[ch];
      if (edge_hit[ch]) begin
        if (tx_control_ff[ch][line_tx_pkg::bit_all_ones]) begin
          // Unframed all ones: marks alternate between the rails on every bit
          nxt_out_pos[ch] = !out_pos_ff[ch]; // RULE_06
          nxt_out_neg[ch] = out_pos_ff[ch]; // RULE_06
        end else if (prbs_gen_enable[ch]) begin
          // Test pattern on the positive rail; a pending error inverts one bit
          nxt_out_pos[ch] = prbs_data[ch] ^ err_ff[ch]; // RULE_03
          nxt_out_neg[ch] = 1'b0;
        end else begin
          nxt_out_pos[ch] = pos_sync_ff[ch]; // RULE_06
          nxt_out_neg[ch] = neg_sync_ff[ch]; // RULE_06
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      out_pos_ff <= '0;
      out_neg_ff <= '0;
    end else begin
      out_pos_ff <= nxt_out_pos;
      out_neg_ff <= nxt_out_neg;
    end
  end

  // Drive monitor: counts silent bit periods, saturating so the alarm holds
  always_comb begin
    for (int ch = 0; ch < line_tx_pkg::num_channels; ch++) begin
      if (tx_control_ff[ch][line_tx_pkg::bit_internal_monitor]) begin
        pulse_seen[ch] = out_pos_ff[ch] ^ out_neg_ff[ch]; // RULE_01
      end else begin
        pulse_seen[ch] = mp_sync_ff[ch] ^ mn_sync_ff[ch]; // RULE_01
      end
      nxt_silent[ch] = silent_ff[ch];
      nxt_alarm[ch] = alarm_ff[ch];
      if (pulse_seen[ch]) begin
        nxt_silent[ch] = '0; // RULE_02
        nxt_alarm[ch] = 1'b0; // RULE_02
      end else if (edge_hit[ch]) begin
        if (silent_ff[ch] != line_tx_pkg::monitor_count_max) begin
          nxt_silent[ch] = silent_ff[ch] + 8'h01;
        end
        if (silent_ff[ch] + 8'h01 >= line_tx_pkg::monitor_count_max) begin
          nxt_alarm[ch] = 1'b1; // RULE_02
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    for (int ch = 0; ch < line_tx_pkg::num_channels; ch++) begin
      if (!nrst) begin
        silent_ff[ch] <= '0;
      end else begin
        silent_ff[ch] <= nxt_silent[ch];
      end
    end
    if (!nrst) begin
      alarm_ff <= '0;
    end else begin
      alarm_ff <= nxt_alarm;
    end
  end

  always_comb begin
    cpu_rdata = '0;
    if (cpu_sub_address == line_tx_pkg::sub_tx_control && cpu_channel < 4'(line_tx_pkg::num_channels)) begin
      cpu_rdata = tx_control_ff[cpu_channel]; // RULE_11
    end
  end

  always_comb begin
    for (int ch = 0; ch < line_tx_pkg::num_channels; ch++) begin
      line_buildout_enable[ch] = tx_control_ff[ch][line_tx_pkg::bit_buildout] && !mode_e3[ch]; // RULE_09
    end
  end

  assign line_out_positive = out_pos_ff;
  assign line_out_negative = out_neg_ff;
  assign prbs_error_insert = err_ff;
  assign drive_monitor_alarm = alarm_ff;
endmodule : line_tx_channel_control

// file: hw/line_tx_pkg.sv
package line_tx_pkg;
  localparam int num_channels = 12;
  // Register page per channel: sub-address of the transmit control register
  localparam logic [3:0] sub_tx_control = 4'h4;
  localparam logic [7:0] tx_control_reset = 8'h00;
  localparam logic [7:0] tx_control_mask = 8'h37;
  localparam int bit_buildout = 0;
  localparam int bit_clock_edge = 1;
  localparam int bit_all_ones = 2;
  localparam int bit_insert_error = 4;
  localparam int bit_internal_monitor = 5;
  localparam int monitor_silent_bits = 128;
  localparam logic [7:0] monitor_count_max = 8'h80;

  typedef struct packed {
    logic pos;
    logic neg;
  } rail_s;
endpackage : line_tx_pkg

// file: tb/line_tx_assertions.sv
module line_tx_assertions (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [3:0] cpu_channel,
  input wire logic [3:0] cpu_sub_address,
  input wire logic cpu_write,
  input wire logic [7:0] cpu_wdata,
  input wire logic [7:0] cpu_rdata,
  input wire logic [11:0] mode_e3,
  input wire logic [11:0] prbs_gen_enable,
  input wire logic [11:0] prbs_rx_enable,
  input wire logic [11:0] line_buildout_enable,
  input wire logic [11:0] prbs_error_insert
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  chk_reserved_zero: assert property ((cpu_rdata & 8'hc8) == 8'h00)
    else $error("reserved bit set");
  chk_unmapped_zero: assert property ((cpu_sub_address != 4'h4 || cpu_channel > 4'hb) |-> cpu_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_write_visible: assert property (cpu_write && cpu_sub_address == 4'h4 && cpu_channel < 4'hc ##1
    $stable(cpu_channel) && cpu_sub_address == 4'h4 |-> cpu_rdata == ($past(cpu_wdata) & 8'h37))
    else $error("written value not read back");
  chk_buildout_e3: assert property ((line_buildout_enable & mode_e3) == 12'h000)
    else $error("buildout active in e3");
  chk_buildout_follows: assert property (cpu_channel == 4'h3 && cpu_sub_address == 4'h4 |->
    line_buildout_enable[3] == (cpu_rdata[0] && !mode_e3[3])) else $error("buildout mismatch");
  chk_insert_gated: assert property ($rose(prbs_error_insert[0]) |-> $past(prbs_gen_enable[0] && prbs_rx_enable[0]))
    else $error("insert while disabled");
  chk_insert_cause: assert property ($rose(prbs_error_insert[0]) |->
    $past(cpu_write && cpu_channel == 4'h0 && cpu_sub_address == 4'h4 && cpu_wdata[4])) else $error("insert without write");
  chk_insert_clears: assert property (prbs_error_insert[0] |-> ##[1:40] !prbs_error_insert[0])
    else $error("insert stuck");
endmodule : line_tx_assertions

bind line_tx_channel_control line_tx_assertions u_chk (.clk_sys, .nrst, .cpu_channel, .cpu_sub_address, .cpu_write,
  .cpu_wdata, .cpu_rdata, .mode_e3, .prbs_gen_enable, .prbs_rx_enable, .line_buildout_enable, .prbs_error_insert);

// file: tb/line_tx_channel_control_tb.sv
module line_tx_channel_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] cpu_channel = 4'h0;
  logic [3:0] cpu_sub_address = 4'h4;
  logic cpu_write = 1'b0;
  logic [7:0] cpu_wdata = 8'h00;
  logic [11:0] mode_e3 = 12'h000;
  logic [11:0] prbs_gen_enable = 12'h000;
  logic [11:0] prbs_rx_enable = 12'h000;
  wire [7:0] cpu_rdata;
  wire [11:0] system_tx_clock, system_tx_data_pos, system_tx_data_neg, line_out_positive, line_out_negative;
  wire [11:0] line_buildout_enable, prbs_error_insert, drive_monitor_alarm;
  int err_count = 0;
  int comparisons = 0;
  int h;
  int r;
  always #2.5 clk_sys = ~clk_sys;
  line_tx_framer_model u_framer (.system_tx_clock, .system_tx_data_pos, .system_tx_data_neg);
  line_tx_channel_control u_dut (.clk_sys, .nrst, .cpu_channel, .cpu_sub_address, .cpu_write, .cpu_wdata,
    .cpu_rdata, .mode_e3, .prbs_gen_enable, .prbs_rx_enable, .prbs_data(12'h000), .system_tx_clock,
    .system_tx_data_pos, .system_tx_data_neg, .monitor_in_positive(12'h000), .monitor_in_negative(12'h000),
    .line_out_positive, .line_out_negative, .line_buildout_enable, .prbs_error_insert, .drive_monitor_alarm);
  task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
    comparisons++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask : chk
  task automatic acc(input logic [3:0] c, input logic [3:0] s, input logic [7:0] v, input logic w, input logic [7:0] e);
    @(posedge clk_sys);
    cpu_channel <= c;
    cpu_sub_address <= s;
    cpu_wdata <= v;
    cpu_write <= w;
    @(posedge clk_sys);
    cpu_write <= 1'b0;
    #1;
    if (!w) chk("rdata", e, cpu_rdata);
  endtask : acc
  // Counts marked cycles and positive-rail rises over roughly six line bits
  task automatic watch(input int ch);
    logic p;
    p = line_out_positive[ch];
    h = 0;
    r = 0;
    repeat (80) begin
      @(posedge clk_sys);
      #1;
      h += int'(line_out_positive[ch] | line_out_negative[ch]);
      r += int'(line_out_positive[ch] & !p);
      p = line_out_positive[ch];
    end
  endtask : watch
  task automatic complete_run;
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  initial begin
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    acc(6, 4, 8'h04, 1, 0);
    acc(7, 4, 8'h24, 1, 0);
    acc(5, 4, 8'h22, 1, 0);
    acc(3, 4, 8'hff, 1, 0);
    acc(3, 4, 0, 0, 8'h37);
    acc(4, 4, 0, 0, 8'h00);
    acc(3, 5, 0, 0, 8'h00);
    acc(12, 4, 0, 0, 8'h00);
    acc(8, 4, 8'h01, 1, 0);
    chk("buildout", 12'h108, line_buildout_enable);
    @(posedge clk_sys);
    mode_e3 <= 12'h008;
    acc(3, 4, 0, 0, 8'h37);
    chk("buildout_e3", 12'h100, line_buildout_enable);
    watch(1);
    chk("falling_edge", 1, h > 0);
    acc(1, 4, 8'h02, 1, 0);
    watch(1);
    watch(1);
    chk("rising_edge", 0, h > 0);
    acc(2, 4, 8'h06, 1, 0);
    watch(2);
    chk("all_ones", 1, r > 1);
    @(posedge clk_sys);
    prbs_gen_enable <= 12'h001;
    prbs_rx_enable <= 12'h001;
    acc(0, 4, 8'h02, 1, 0);
    watch(0);
    acc(0, 4, 8'h12, 1, 0);
    chk("insert_pending", 1, prbs_error_insert[0]);
    watch(0);
    chk("one_error", 1, r);
    chk("insert_spent", 0, prbs_error_insert[0]);
    acc(0, 4, 8'h12, 1, 0);
    watch(0);
    chk("held_one", 0, r);
    acc(0, 4, 8'h02, 1, 0);
    acc(0, 4, 8'h12, 1, 0);
    watch(0);
    chk("rearmed", 1, r);
    @(posedge clk_sys);
    prbs_rx_enable <= 12'h000;
    acc(0, 4, 8'h02, 1, 0);
    acc(0, 4, 8'h12, 1, 0);
    watch(0);
    chk("gated", 0, r);
    repeat (1500) @(posedge clk_sys);
    chk("ext_monitor", 1, drive_monitor_alarm[6]);
    chk("int_monitor", 0, drive_monitor_alarm[7]);
    chk("silent_alarm", 1, drive_monitor_alarm[5]);
    acc(5, 4, 8'h26, 1, 0);
    watch(5);
    chk("alarm_clear", 0, drive_monitor_alarm[5]);
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    complete_run();
  end
endmodule : line_tx_channel_control_tb

// file: tb/line_tx_framer_model.sv
module line_tx_framer_model (
  output logic [11:0] system_tx_clock,
  output logic [11:0] system_tx_data_pos,
  output logic [11:0] system_tx_data_neg
);
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_link = 1'b0;
  // Data lags by a quarter period so the two clock edges sample different bits
  always #32 clk_link = ~clk_link;
  assign system_tx_clock = {12{clk_link}};
  assign #16 system_tx_data_pos = {12{clk_link}};
  assign system_tx_data_neg = 12'h000;
endmodule : line_tx_framer_model
